//--- design/reset_watchdog_regs.vh
// Purpose: Register map, field positions, reset values and timing counts
//          of the reset and watchdog block.
// Assumes: 32-bit classic Wishbone, one aligned word per register.
// Notes:   Definitions only.
`ifndef RESET_WATCHDOG_REGS_VH
`define RESET_WATCHDOG_REGS_VH

// ==========================================================
// Register byte offsets
`define RW_OFS_SETUP 5'h00
`define RW_OFS_SERVICE 5'h04
`define RW_OFS_CONTROL 5'h08
`define RW_OFS_STATUS 5'h0C

// ==========================================================
// Setup register fields
`define RW_SETUP_EDGE 5
`define RW_SETUP_STOP_DELAY 4
`define RW_SETUP_CMON_EN 3
`define RW_SETUP_RATE_HI 1
`define RW_SETUP_RATE_LO 0
`define RW_SETUP_RST 8'h10
`define RW_SETUP_PROT_MASK 8'h33
`define RW_SETUP_FREE_MASK 8'h08

// ==========================================================
// Control and status fields
`define RW_CTRL_WD_DISABLE 0
`define RW_STAT_WD_ACTIVE 0
`define RW_STAT_ARMED 1
`define RW_STAT_WIN_OPEN 2
`define RW_STAT_CAUSE_LSB 4
`define RW_CAUSE_POR 4'h1
`define RW_CAUSE_EXT 4'h2
`define RW_CAUSE_WDOG 4'h4
`define RW_CAUSE_CMON 4'h8

// ==========================================================
// Service key values
`define RW_SVC_ARM 8'h55
`define RW_SVC_CLR 8'hAA

// ==========================================================
// Timing counts in bus clock cycles, prescaler width, clock rates in Hz and monitor period in ns
`define RW_WINDOW_CYCLES 7'h40
`define RW_STOP_DELAY_CYCLES 12'hFE0
`define RW_POR_DELAY_CYCLES 13'h0FE0
`define RW_PIN_DRIVE_CYCLES 13'h0010
`define RW_PRESCALE_BITS 15
`define RW_CLK_HZ 25000000
`define RW_CMON_FAIL_HZ 10000
`define RW_CMON_REF_NS 100000

`endif

//--- design/clock_monitor.v
// Purpose: Flags a bus clock that runs too slow against a reference tick.
// Assumes: ref_tick_in is a one-cycle pulse once per reference period.
// Notes:   A fully stopped clock cannot be seen by logic on that clock.
`default_nettype none
`timescale 1ns/1ps
`include "reset_watchdog_regs.vh"

module clock_monitor #(
  parameter integer REF_NS = `RW_CMON_REF_NS,
  parameter integer FAIL_HZ = `RW_CMON_FAIL_HZ
) (
  input wire clk_sys_in, // Bus clock
  input wire resetn_in, // Async reset, active low
  input wire enable_in, // Monitor on
  input wire ref_tick_in, // Reference period pulse
  output reg fail_out // One-cycle fail pulse
);

  // Edges expected at the fail rate in one period, plus one
  localparam integer MIN_EDGES = (FAIL_HZ / 1000) * (REF_NS / 1000) / 1000 + 1;
  localparam [7:0] MIN_EDGES_W = MIN_EDGES[7:0];

  reg [7:0] edge_cnt_q;
  reg primed_q;

  // ==========================================================
  // Edge count per reference period
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      edge_cnt_q <= 8'h00;
      primed_q <= 1'b0;
      fail_out <= 1'b0;
    end else if (!enable_in) begin
      edge_cnt_q <= 8'h00;
      primed_q <= 1'b0;
      fail_out <= 1'b0;
    end else if (ref_tick_in) begin
      edge_cnt_q <= 8'h00;
      primed_q <= 1'b1;
      fail_out <= primed_q && (edge_cnt_q < MIN_EDGES_W);
    end else begin
      fail_out <= 1'b0;
      if (edge_cnt_q != 8'hFF) begin
        edge_cnt_q <= edge_cnt_q + 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

//--- design/reset_watchdog.v
// Purpose: Reset sequencing, watchdog, clock monitor and setup register.
// Assumes: Classic Wishbone slave, 25 MHz bus clock, synchronous inputs.
// Notes:   Every internal reset returns the setup state to reset values.
//
// The Wishbone register port and the register offsets were left to the implementer.
`default_nettype none
`timescale 1ns/1ps
`include "reset_watchdog_regs.vh"

module reset_watchdog #(
  parameter integer PRESCALE_BITS = `RW_PRESCALE_BITS,
  parameter [12:0] POR_DELAY = `RW_POR_DELAY_CYCLES
) (
  input wire clk_sys_in, // Bus clock
  input wire resetn_in, // Power-on reset, active low
  input wire wb_cyc_in, // Wishbone cycle
  input wire wb_stb_in, // Wishbone strobe
  input wire wb_we_in, // Wishbone write
  input wire [4:0] wb_adr_in, // Byte address
  input wire [3:0] wb_sel_in, // Byte lanes
  input wire [31:0] wb_dat_in, // Write data
  output reg [31:0] wb_dat_out, // Read data
  output reg wb_ack_out, // Acknowledge
  input wire reset_pin_in, // Reset pin level
  output wire reset_pin_out, // Reset pin drive value
  output wire reset_pin_oe_n_out, // Reset pin enable, low drives
  input wire special_mode_flag_in, // Special mode
  input wire cmon_ref_tick_in, // Clock monitor reference pulse
  input wire irq_n_in, // External interrupt, active low
  input wire irq_ack_in, // Clears a latched edge
  output wire irq_request_out, // Interrupt request
  input wire stop_wakeup_in, // Stop mode wakeup pulse
  output reg stop_resume_out, // Resume pulse
  output wire sys_reset_out // Block in reset
);

  // ==========================================================
  // Sequencer states
  localparam [1:0] ST_POR = 2'h0;
  localparam [1:0] ST_HOLD = 2'h1;
  localparam [1:0] ST_DRIVE = 2'h2;
  localparam [1:0] ST_RUN = 2'h3;

  localparam integer CNT_W = PRESCALE_BITS + 6;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [12:0] seq_cnt_q;
  reg [3:0] cause_q;
  reg [7:0] setup_q;
  reg setup_done_q;
  reg [6:0] win_cnt_q;
  reg wd_dis_q;
  reg wd_dis_done_q;
  reg armed_q;
  reg [CNT_W-1:0] wd_cnt_q;
  reg irq_prev_q;
  reg irq_edge_q;
  reg stop_busy_q;
  reg [11:0] stop_cnt_q;
  reg [CNT_W-1:0] wd_limit;
  reg [31:0] rd_data;

  wire in_reset;
  wire run;
  wire bus_req;
  wire wr_fire;
  wire wr_lane0;
  wire [7:0] wr_byte;
  wire win_open;
  wire prot_ok;
  wire wd_active;
  wire wd_timeout;
  wire cmon_fail;
  wire sel_setup;
  wire sel_service;
  wire sel_control;
  wire sel_status;

  assign in_reset = (state_q != ST_RUN);
  assign run = ~in_reset;
  assign sys_reset_out = in_reset;

  // ==========================================================
  // Wishbone decode
  assign bus_req = wb_cyc_in & wb_stb_in;
  assign wr_fire = bus_req & wb_we_in & wb_ack_out;
  assign wr_lane0 = wr_fire & wb_sel_in[0] & run;
  assign wr_byte = wb_dat_in[7:0];
  localparam [4:0] OFS_SETUP = `RW_OFS_SETUP;
  localparam [4:0] OFS_SERVICE = `RW_OFS_SERVICE;
  localparam [4:0] OFS_CONTROL = `RW_OFS_CONTROL;
  localparam [4:0] OFS_STATUS = `RW_OFS_STATUS;
  assign sel_setup = (wb_adr_in[4:2] == OFS_SETUP[4:2]);
  assign sel_service = (wb_adr_in[4:2] == OFS_SERVICE[4:2]);
  assign sel_control = (wb_adr_in[4:2] == OFS_CONTROL[4:2]);
  assign sel_status = (wb_adr_in[4:2] == OFS_STATUS[4:2]);

  always @* begin
    rd_data = 32'h00000000;
    if (sel_setup) begin
      rd_data[7:0] = setup_q & (`RW_SETUP_PROT_MASK | `RW_SETUP_FREE_MASK);
    end else if (sel_control) begin
      rd_data[`RW_CTRL_WD_DISABLE] = wd_dis_q;
    end else if (sel_status) begin
      rd_data[`RW_STAT_WD_ACTIVE] = wd_active;
      rd_data[`RW_STAT_ARMED] = armed_q;
      rd_data[`RW_STAT_WIN_OPEN] = win_open;
      rd_data[`RW_STAT_CAUSE_LSB+3:`RW_STAT_CAUSE_LSB] = cause_q;
    end
  end

  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      wb_ack_out <= bus_req & ~wb_ack_out;
      if (bus_req & ~wb_ack_out) begin
        wb_dat_out <= wb_we_in ? 32'h00000000 : rd_data;
      end
    end
  end

  // ==========================================================
  // Reset sequencer
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_POR: begin
        if (seq_cnt_q == POR_DELAY - 13'h0001) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (reset_pin_in) begin
          state_d = ST_RUN;
        end
      end
      ST_DRIVE: begin
        if (seq_cnt_q == `RW_PIN_DRIVE_CYCLES - 13'h0001) begin
          state_d = ST_HOLD;
        end
      end
      ST_RUN: begin
        if (wd_timeout | cmon_fail) begin
          state_d = ST_DRIVE;
        end else if (!reset_pin_in) begin
          state_d = ST_HOLD;
        end
      end
      default: begin
        state_d = ST_POR;
      end
    endcase
  end

  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= ST_POR;
      seq_cnt_q <= 13'h0000;
      cause_q <= `RW_CAUSE_POR;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) begin
        seq_cnt_q <= 13'h0000;
      end else begin
        seq_cnt_q <= seq_cnt_q + 13'h0001;
      end
      if (state_q == ST_RUN) begin
        if (wd_timeout) begin
          cause_q <= `RW_CAUSE_WDOG;
        end else if (cmon_fail) begin
          cause_q <= `RW_CAUSE_CMON;
        end else if (!reset_pin_in) begin
          cause_q <= `RW_CAUSE_EXT;
        end
      end
    end
  end

  // Pin driven low only during the internal drive phase
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe_n_out = (state_q != ST_DRIVE);

  // ==========================================================
  // Setup register and write-once protection
  assign win_open = (win_cnt_q < `RW_WINDOW_CYCLES);
  assign prot_ok = special_mode_flag_in | (win_open & ~setup_done_q);

  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      setup_q <= `RW_SETUP_RST;
      setup_done_q <= 1'b0;
      win_cnt_q <= 7'h00;
    end else if (in_reset) begin
      setup_q <= `RW_SETUP_RST;
      setup_done_q <= 1'b0;
      win_cnt_q <= 7'h00;
    end else begin
      if (win_open) begin
        win_cnt_q <= win_cnt_q + 7'h01;
      end
      if (wr_lane0 & sel_setup) begin
        setup_q[`RW_SETUP_CMON_EN] <= wr_byte[`RW_SETUP_CMON_EN];
        if (prot_ok) begin
          setup_q[`RW_SETUP_EDGE] <= wr_byte[`RW_SETUP_EDGE];
          setup_q[`RW_SETUP_STOP_DELAY] <= wr_byte[`RW_SETUP_STOP_DELAY];
          setup_q[`RW_SETUP_RATE_HI] <= wr_byte[`RW_SETUP_RATE_HI];
          setup_q[`RW_SETUP_RATE_LO] <= wr_byte[`RW_SETUP_RATE_LO];
          setup_done_q <= ~special_mode_flag_in;
        end
      end
    end
  end

  // ==========================================================
  // Watchdog disable, write once in normal modes
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wd_dis_q <= 1'b0;
      wd_dis_done_q <= 1'b0;
    end else if (in_reset) begin
      wd_dis_q <= 1'b0;
      wd_dis_done_q <= 1'b0;
    end else if (wr_lane0 & sel_control) begin
      if (special_mode_flag_in | ~wd_dis_done_q) begin
        wd_dis_q <= wr_byte[`RW_CTRL_WD_DISABLE];
        wd_dis_done_q <= 1'b1;
      end
    end
  end

  assign wd_active = run & ~wd_dis_q;

  // ==========================================================
  // Watchdog counter
  always @* begin
    wd_limit = {CNT_W{1'b0}};
    case ({setup_q[`RW_SETUP_RATE_HI], setup_q[`RW_SETUP_RATE_LO]})
      2'h0: wd_limit[PRESCALE_BITS-1:0] = {PRESCALE_BITS{1'b1}};
      2'h1: wd_limit[PRESCALE_BITS+1:0] = {(PRESCALE_BITS+2){1'b1}};
      2'h2: wd_limit[PRESCALE_BITS+3:0] = {(PRESCALE_BITS+4){1'b1}};
      default: wd_limit = {CNT_W{1'b1}};
    endcase
  end

  assign wd_timeout = wd_active & (wd_cnt_q == wd_limit);

  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wd_cnt_q <= {CNT_W{1'b0}};
      armed_q <= 1'b0;
    end else if (in_reset) begin
      wd_cnt_q <= {CNT_W{1'b0}};
      armed_q <= 1'b0;
    end else begin
      if (wr_lane0 & sel_service & armed_q & (wr_byte == `RW_SVC_CLR)) begin
        wd_cnt_q <= {CNT_W{1'b0}};
      end else if (wd_active) begin
        wd_cnt_q <= wd_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (wr_lane0 & sel_service) begin
        armed_q <= (wr_byte == `RW_SVC_ARM);
      end
    end
  end

  // ==========================================================
  // Clock monitor
  clock_monitor u_cmon (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .enable_in(run & setup_q[`RW_SETUP_CMON_EN]),
    .ref_tick_in(cmon_ref_tick_in),
    .fail_out(cmon_fail)
  );

  // ==========================================================
  // External interrupt sensing
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_prev_q <= 1'b1;
      irq_edge_q <= 1'b0;
    end else begin
      irq_prev_q <= irq_n_in;
      if (in_reset) begin
        irq_edge_q <= 1'b0;
      end else if (irq_prev_q & ~irq_n_in) begin
        irq_edge_q <= 1'b1;
      end else if (irq_ack_in) begin
        irq_edge_q <= 1'b0;
      end
    end
  end

  assign irq_request_out = run & (setup_q[`RW_SETUP_EDGE] ? irq_edge_q : ~irq_n_in);

  // ==========================================================
  // Stop mode exit delay
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stop_busy_q <= 1'b0;
      stop_cnt_q <= 12'h000;
      stop_resume_out <= 1'b0;
    end else if (in_reset) begin
      stop_busy_q <= 1'b0;
      stop_cnt_q <= 12'h000;
      stop_resume_out <= 1'b0;
    end else begin
      stop_resume_out <= 1'b0;
      if (stop_busy_q) begin
        if (stop_cnt_q == `RW_STOP_DELAY_CYCLES - 12'h001) begin
          stop_busy_q <= 1'b0;
          stop_resume_out <= 1'b1;
        end else begin
          stop_cnt_q <= stop_cnt_q + 12'h001;
        end
      end else if (stop_wakeup_in) begin
        stop_cnt_q <= 12'h000;
        if (setup_q[`RW_SETUP_STOP_DELAY]) begin
          stop_busy_q <= 1'b1;
        end else begin
          stop_resume_out <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- tb/reset_watchdog_sva.sv
// Purpose: Port-level assertions for reset_watchdog.
// Assumes: Single bus clock domain, async active-low reset.
// Notes:   Bound to every reset_watchdog instance.
`timescale 1ns/1ps
`default_nettype none
module reset_watchdog_sva (
  input wire logic clk_sys_in, // Bus clock
  input wire logic resetn_in, // Reset, active low
  input wire logic wb_cyc_in, // Cycle
  input wire logic wb_stb_in, // Strobe
  input wire logic wb_we_in, // Write
  input wire logic [4:0] wb_adr_in, // Address
  input wire logic [31:0] wb_dat_out, // Read data
  input wire logic wb_ack_out, // Ack
  input wire logic reset_pin_in, // Pin level
  input wire logic reset_pin_oe_n_out, // Pin enable
  input wire logic irq_request_out, // Irq request
  input wire logic stop_resume_out, // Resume pulse
  input wire logic sys_reset_out // In reset
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  // ==========================================================
  // Bus
  a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_ack_after_req: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing after request");
  a_setup_unused_zero: assert property (wb_ack_out && !$past(wb_we_in) &&
    $past(wb_adr_in[4:2]) == 3'h0 |-> wb_dat_out[7:6] == 2'h0 && !wb_dat_out[2])
    else $error("unused setup bits read nonzero");
  a_unmapped_zero: assert property (wb_ack_out && !$past(wb_we_in) && $past(wb_adr_in[4])
    |-> wb_dat_out == 32'h0) else $error("unmapped read nonzero");
  // ==========================================================
  // Reset sequencing
  a_pin_drive_len: assert property ($fell(reset_pin_oe_n_out) |->
    (!reset_pin_oe_n_out)[*8] ##1 (!reset_pin_oe_n_out)[*8] ##1 reset_pin_oe_n_out)
    else $error("pin drive length wrong");
  a_drive_in_reset: assert property (!reset_pin_oe_n_out |-> sys_reset_out)
    else $error("pin driven outside reset");
  a_hold_while_low: assert property (sys_reset_out && !reset_pin_in |=> sys_reset_out)
    else $error("left reset with pin low");
  a_ext_enters: assert property (!sys_reset_out && !reset_pin_in |-> ##[1:3] sys_reset_out)
    else $error("pin low did not reset");
  a_por_hold: assert property ($rose(resetn_in) |-> sys_reset_out[*4])
    else $error("power-on delay too short");
  a_irq_quiet: assert property (sys_reset_out |-> !irq_request_out)
    else $error("irq request in reset");
  a_resume_pulse: assert property (stop_resume_out |=> !stop_resume_out)
    else $error("resume longer than one cycle");
endmodule
bind reset_watchdog reset_watchdog_sva i_sva (.clk_sys_in, .resetn_in, .wb_cyc_in,
  .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out, .reset_pin_in,
  .reset_pin_oe_n_out, .irq_request_out, .stop_resume_out, .sys_reset_out);
`default_nettype wire

//--- tb/reset_watchdog_test.sv
// Purpose: Self-checking bench for reset_watchdog.
// Assumes: PRESCALE_BITS 4 and POR_DELAY 4 to keep counts short.
// Notes:   Pin level resolved from block drive and bench drive.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module reset_watchdog_test;
  logic clk_sys_in = 0, resetn_in = 0, cyc = 0, we = 0, ext_q = 1, spec_mode = 0, tick = 0;
  logic irq_n = 1, irq_ack = 0, wake = 0, pin_oe_n, pin_out, irq_req, resume, sys_rst, ack;
  logic [4:0] adr = 0;
  logic [7:0] d8;
  logic [31:0] wdat = 0, rdat, q;
  wire pin_lvl = pin_oe_n ? ext_q : pin_out;
  int error_cnt = 0, comparisons = 0, now = 0, t0, r, k, w;
  reset_watchdog #(.PRESCALE_BITS(4), .POR_DELAY(13'h0004)) i_dut (.clk_sys_in, .resetn_in,
    .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .reset_pin_in(pin_lvl),
    .reset_pin_out(pin_out), .reset_pin_oe_n_out(pin_oe_n), .special_mode_flag_in(spec_mode),
    .cmon_ref_tick_in(tick), .irq_n_in(irq_n), .irq_ack_in(irq_ack),
    .irq_request_out(irq_req), .stop_wakeup_in(wake), .stop_resume_out(resume),
    .sys_reset_out(sys_rst));
  initial forever #20 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) now <= now + 1;
  // ==========================================================
  // Helpers
  function int tmo(input int rt);
    tmo = 16 << (2 * rt);
  endfunction
  function logic near(input int e, input int g);
    near = g >= e - 2 && g <= e + 3;
  endfunction
  function logic hit(input int m);
    case (m)
      0: hit = sys_rst === 1'b0 && pin_oe_n === 1'b1;
      1: hit = pin_oe_n === 1'b0;
      default: hit = resume === 1'b1;
    endcase
  endfunction
  task finish_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wait_for(input int m, input int lim);
    w = 0;
    while (!hit(m) && w < lim) begin
      @(negedge clk_sys_in);
      w++;
    end
    if (w >= lim) begin
      error_cnt++;
      finish_test();
    end
  endtask
  task bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    cyc <= 1;
    we <= wr;
    adr <= a;
    wdat <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      error_cnt++;
      finish_test();
    end
    q = rdat;
    cyc <= 0;
  endtask
  task do_reset(input logic pin);
    @(posedge clk_sys_in);
    resetn_in <= 0;
    ext_q <= pin;
    repeat (6) @(posedge clk_sys_in);
    resetn_in <= 1;
    if (pin) wait_for(0, 50);
    t0 = now;
  endtask
  task tick_run(input int hi, input int gap, input int n);
    repeat (n) begin
      @(posedge clk_sys_in) tick <= 1;
      repeat (hi) @(posedge clk_sys_in);
      tick <= 0;
      repeat (gap) @(posedge clk_sys_in);
    end
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(8037));
    do_reset(1);
    bus(0, 5'h00, 0); `CHK("setup reset", 32'h10, q)
    bus(0, 5'h0C, 0); `CHK("wd active", 1'b1, q[0])
    `CHK("window open", 1'b1, q[2])
    for (r = 0; r < 4; r++) begin
      do_reset(1);
      d8 = {2'b11, 1'($urandom), 3'b101, r[1:0]};
      bus(1, 5'h00, d8);
      bus(0, 5'h00, 0); `CHK("setup write", d8 & 8'h3B, q[7:0])
      wait_for(1, 1100);
      `CHK("timeout", 1'b1, near(tmo(r), now - t0))
      `CHK("pin low", 1'b0, pin_lvl)
      wait_for(0, 60);
      bus(0, 5'h0C, 0); `CHK("wd cause", 4'h4, q[7:4])
      bus(0, 5'h00, 0); `CHK("rate cleared", 32'h10, q)
    end
    do_reset(1);
    bus(1, 5'h00, 8'h23);
    bus(1, 5'h00, 8'h00);
    bus(1, 5'h00, 8'h08);
    bus(0, 5'h00, 0); `CHK("write once", 32'h2B, q)
    for (r = 0; r < 5; r++) begin
      bus(1, 5'h04, 8'h55);
      repeat ($urandom_range(3)) bus(0, 5'h0C, 0);
      bus(1, 5'h14, 8'($urandom));
      bus(1, 5'h04, 8'hAA);
      repeat (900) @(posedge clk_sys_in);
    end
    `CHK("serviced", 1'b0, sys_rst)
    bus(1, 5'h04, 8'h55);
    bus(1, 5'h04, 8'hAA);
    t0 = now;
    bus(1, 5'h04, 8'h55);
    bus(0, 5'h0C, 0); `CHK("armed", 1'b1, q[1])
    bus(1, 5'h04, 8'($urandom_range(84)));
    bus(0, 5'h0C, 0); `CHK("arm dropped", 1'b0, q[1])
    bus(1, 5'h04, 8'hAA);
    wait_for(1, 1100);
    `CHK("disarmed", 1'b1, near(tmo(3), now - t0))
    do_reset(1);
    bus(1, 5'h08, 8'h01);
    bus(1, 5'h08, 8'h00);
    bus(0, 5'h0C, 0); `CHK("wd off", 1'b0, q[0])
    bus(0, 5'h14, 0); `CHK("unmapped", 32'h0, q)
    repeat (1100) @(posedge clk_sys_in);
    `CHK("no timeout", 1'b0, sys_rst)
    bus(0, 5'h0C, 0); `CHK("window shut", 1'b0, q[2])
    tick_run(4, 1, 2); `CHK("cmon off", 1'b0, sys_rst)
    bus(1, 5'h00, 8'h08);
    tick_run(1, 40, 3); `CHK("slow ticks", 1'b0, sys_rst)
    tick_run(4, 1, 1);
    wait_for(1, 20);
    wait_for(0, 60);
    bus(0, 5'h0C, 0); `CHK("cmon cause", 4'h8, q[7:4])
    do_reset(0);
    repeat (20) @(posedge clk_sys_in);
    `CHK("por hold", 1'b1, sys_rst)
    ext_q <= 1;
    wait_for(0, 10);
    bus(1, 5'h08, 8'h01);
    ext_q <= 0;
    repeat (8) @(posedge clk_sys_in);
    `CHK("ext reset", 1'b1, sys_rst)
    ext_q <= 1;
    wait_for(0, 10);
    bus(0, 5'h0C, 0); `CHK("ext cause", 4'h2, q[7:4])
    bus(1, 5'h08, 8'h01);
    irq_n <= 0;
    @(negedge clk_sys_in); `CHK("level on", 1'b1, irq_req)
    @(posedge clk_sys_in) irq_n <= 1;
    @(negedge clk_sys_in); `CHK("level off", 1'b0, irq_req)
    repeat (70) @(posedge clk_sys_in);
    spec_mode <= 1;
    bus(1, 5'h00, 8'h30);
    bus(0, 5'h00, 0); `CHK("special", 32'h30, q)
    irq_n <= 0;
    @(posedge clk_sys_in) irq_n <= 1;
    @(negedge clk_sys_in); `CHK("edge held", 1'b1, irq_req)
    @(posedge clk_sys_in) irq_ack <= 1;
    @(posedge clk_sys_in) irq_ack <= 0;
    @(negedge clk_sys_in); `CHK("edge cleared", 1'b0, irq_req)
    for (r = 1; r >= 0; r--) begin
      bus(1, 5'h00, {3'b001, r[0], 4'h0});
      @(posedge clk_sys_in) wake <= 1;
      t0 = now;
      @(posedge clk_sys_in) wake <= 0;
      wait_for(2, 4200);
      `CHK("resume", 1'b1, near(r ? 4065 : 1, now - t0))
    end
    finish_test();
  end
endmodule
`default_nettype wire
